/* File: common/word_add_pkg.sv */
/*
 * constants for the signed word add datapath: instruction field positions,
 * decode values, widths and reset values.
 * assumes a 64-bit general register file of 32 entries behind the datapath.
 */
package word_add_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int WORD_W = 32;
    localparam int REG_W = 64;
    localparam int REG_COUNT = 32;
    localparam int IDX_W = 5;

    ////////////////////////////////////////////////////////////////////////
    // instruction field positions
    localparam int OPCODE_MSB = 31;
    localparam int OPCODE_LSB = 26;
    localparam int FIRST_SRC_MSB = 25;
    localparam int FIRST_SRC_LSB = 21;
    localparam int SECOND_SRC_MSB = 20;
    localparam int SECOND_SRC_LSB = 16;
    localparam int DEST_MSB = 15;
    localparam int DEST_LSB = 11;
    localparam int SHAMT_MSB = 10;
    localparam int SHAMT_LSB = 6;
    localparam int FUNCT_MSB = 5;
    localparam int FUNCT_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // decode values
    localparam logic [5:0] OPCODE_SPECIAL = 6'h00;
    localparam logic [5:0] FUNCT_ADD = 6'h20;
    localparam logic [5:0] FUNCT_SUM_NONTRAP = 6'h21;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [63:0] RESULT_RST = 64'h0000_0000_0000_0000;

    // operation kind, gray coded along none -> add -> nontrap -> other
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_ADD = 2'b01,
        OP_NONTRAP = 2'b11,
        OP_OTHER = 2'b10
    } op_t;

    function automatic logic [4:0] field5(input logic [31:0] instr, input int lsb);
        field5 = instr[lsb +: 5];
    endfunction

endpackage

/* File: core/word_adder.sv */
/*
 * combinational 32-bit signed adder with overflow detection and
 * sign extension of the result to the register width.
 * assumes operands are the low words of sign-extended register values.
 */
module word_adder (
    input wire logic [31:0] a_word,
    input wire logic [31:0] b_word,
    output logic [63:0] sum_ext,
    output logic overflow
);

    logic [32:0] temp;

    ////////////////////////////////////////////////////////////////////////
    // 33-bit sum of operands extended with bit 31
    assign temp = {a_word[31], a_word} + {b_word[31], b_word};

    // overflow when the two top bits differ
    assign overflow = temp[32] ^ temp[31];

    assign sum_ext = {{32{temp[31]}}, temp[31:0]};

endmodule

/* File: core/word_add_overflow_trap.sv */
/*
 * signed word add datapath with its own general register file: decodes an
 * issued instruction, adds the two source words, writes the destination or
 * raises an integer overflow exception; a non-trapping variant never traps.
 * assumes the pipeline issues one instruction per cycle at most, keeps
 * source registers sign-extended and keeps the shift field zero.
 */
// Notes on behaviour
// - add second source word to first source word as 32-bit two's complement
// - on overflow leave destination unchanged and raise integer overflow exception
// - without overflow write the sign-extended word result into destination
// - non-trapping variant writes the same sum and never raises the exception
// - opcode zero in bits 31:26, function in 5:0, registers 25:21, 20:16, 15:11
module word_add_overflow_trap (
    input wire logic clk,
    input wire logic nrst,
    input wire logic issue_valid,
    input wire logic [31:0] instr,
    input wire logic load_valid,
    input wire logic [4:0] load_index,
    input wire logic [63:0] load_data,
    input wire logic [4:0] read_index,
    output logic [63:0] read_data_q,
    output logic [63:0] result_q,
    output logic result_valid_q,
    output logic ovf_exception_q,
    output logic unknown_op_q
);

    ////////////////////////////////////////////////////////////////////////
    // register file and its state
    logic [63:0] gpr_q [word_add_pkg::REG_COUNT];
    logic [63:0] result_d;
    logic result_valid_d;
    logic ovf_exception_d;
    logic unknown_op_d;

    ////////////////////////////////////////////////////////////////////////
    // decode
    wire logic [5:0] opcode = instr[word_add_pkg::OPCODE_MSB:word_add_pkg::OPCODE_LSB];
    wire logic [5:0] funct = instr[word_add_pkg::FUNCT_MSB:word_add_pkg::FUNCT_LSB];
    wire logic [4:0] first_source_field =
        word_add_pkg::field5(instr, word_add_pkg::FIRST_SRC_LSB);
    wire logic [4:0] second_source_field =
        word_add_pkg::field5(instr, word_add_pkg::SECOND_SRC_LSB);
    wire logic [4:0] dst_idx = word_add_pkg::field5(instr, word_add_pkg::DEST_LSB);

    word_add_pkg::op_t op;
    // primary opcode and function select the operation
    // the shift field is not looked at; nonzero values are the issuer's fault
    assign op = !issue_valid ? word_add_pkg::OP_NONE :
        (opcode != word_add_pkg::OPCODE_SPECIAL) ? word_add_pkg::OP_OTHER :
        (funct == word_add_pkg::FUNCT_ADD) ? word_add_pkg::OP_ADD :
        (funct == word_add_pkg::FUNCT_SUM_NONTRAP) ? word_add_pkg::OP_NONTRAP :
        word_add_pkg::OP_OTHER;

    wire logic issue_add = (op == word_add_pkg::OP_ADD);
    wire logic issue_nt = (op == word_add_pkg::OP_NONTRAP);

    ////////////////////////////////////////////////////////////////////////
    // operands and adder
    // only the low words are used; upper bits are trusted to match
    wire logic [63:0] src_a = gpr_q[first_source_field];
    wire logic [63:0] src_b = gpr_q[second_source_field];
    wire logic [63:0] dst_old = gpr_q[dst_idx];
    logic [63:0] sum_ext;
    logic ovf;

    word_adder i_word_adder (
        .a_word(src_a[31:0]),
        .b_word(src_b[31:0]),
        .sum_ext(sum_ext),
        .overflow(ovf)
    );

    ////////////////////////////////////////////////////////////////////////
    // write decision
    // a trapping add that overflows writes nothing
    wire logic trap = issue_add && ovf;
    wire logic sum_nontrapping = issue_nt;
    wire logic do_write = (issue_add && !ovf) || sum_nontrapping;

    // result and its valid come from the same edge as the write
    assign result_d = do_write ? sum_ext : result_q;
    assign result_valid_d = do_write;
    // exception request stands in the same cycle as a result would
    assign ovf_exception_d = trap;
    assign unknown_op_d = (op == word_add_pkg::OP_OTHER);

    ////////////////////////////////////////////////////////////////////////
    // register file: the datapath write wins over the side load port,
    // so a load racing a datapath write is lost, whichever entry it targets, not the result
    always_ff @(posedge clk)
    begin
        if (do_write)
        begin
            gpr_q[dst_idx] <= sum_ext;
        end
        else if (load_valid)
        begin
            gpr_q[load_index] <= load_data;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            result_q <= word_add_pkg::RESULT_RST;
            result_valid_q <= 1'b0;
            ovf_exception_q <= 1'b0;
            unknown_op_q <= 1'b0;
            read_data_q <= word_add_pkg::RESULT_RST;
        end
        else
        begin
            result_q <= result_d;
            result_valid_q <= result_valid_d;
            ovf_exception_q <= ovf_exception_d;
            unknown_op_q <= unknown_op_d;
            read_data_q <= gpr_q[read_index];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_trap_raises: assert property (
        issue_add && ovf |=> ovf_exception_q && !result_valid_q)
        else $error("overflowing add did not trap");

    a_trap_keeps_dest: assert property (
        issue_add && ovf && !load_valid |=> gpr_q[$past(dst_idx)] == $past(dst_old))
        else $error("trapping add changed its destination");

    a_result_holds: assert property (
        !do_write |=> $stable(result_q))
        else $error("result changed without a write");

    a_pulse_exclusive: assert property (
        !(result_valid_q && ovf_exception_q))
        else $error("exception and result valid in one cycle");

    a_sum_written: assert property (
        issue_add && !ovf |=> gpr_q[$past(dst_idx)] == $past(sum_ext))
        else $error("non-overflowing add did not write destination");

    a_add_no_exc: assert property (
        issue_add && !ovf |=> result_valid_q && !ovf_exception_q)
        else $error("non-overflowing add did not report a result");

    a_result_value: assert property (
        do_write |=> result_q[31:0] == $past(src_a[31:0]) + $past(src_b[31:0]))
        else $error("result is not the word sum");

    a_sign_extend: assert property (
        result_valid_q |-> result_q[63:32] == {32{result_q[31]}})
        else $error("result not sign extended");

    a_nontrap_quiet: assert property (
        issue_nt |=> result_valid_q && !ovf_exception_q)
        else $error("non-trapping add trapped or did not write");

    a_nontrap_value: assert property (
        issue_nt |=> result_q == $past(sum_ext))
        else $error("non-trapping add result differs from the sum");

    a_nontrap_dest: assert property (
        issue_nt |=> gpr_q[$past(dst_idx)] == $past(sum_ext))
        else $error("non-trapping add did not write destination");

    // only the trapping add raises it
    a_exc_needs_add: assert property (
        ovf_exception_q |-> $past(issue_add))
        else $error("exception raised without a trapping add");

    a_overflow_detect: assert property (
        issue_valid |-> ovf == ((src_a[31] == src_b[31]) && (sum_ext[31] != src_a[31])))
        else $error("overflow flag disagrees with operand signs");

    // other opcodes leave the datapath idle
    a_decode_fields: assert property (
        issue_valid && opcode != word_add_pkg::OPCODE_SPECIAL
        |=> !result_valid_q && !ovf_exception_q && unknown_op_q)
        else $error("non-special opcode was executed");

    a_unknown_funct: assert property (
        issue_valid && opcode == word_add_pkg::OPCODE_SPECIAL
        && funct != word_add_pkg::FUNCT_ADD && funct != word_add_pkg::FUNCT_SUM_NONTRAP
        |=> unknown_op_q && !result_valid_q && !ovf_exception_q)
        else $error("unknown function code was executed");

    a_idle_quiet: assert property (
        !issue_valid |=> !result_valid_q && !ovf_exception_q && !unknown_op_q)
        else $error("pulse raised without an issue");

    // side port: a load lands when no sum is written
    a_load_lands: assert property (
        load_valid && !do_write |=> gpr_q[$past(load_index)] == $past(load_data))
        else $error("side load did not land");

    c_plain_add: cover property (issue_add && !ovf ##1 result_valid_q);
    c_trap: cover property (issue_add && ovf ##1 ovf_exception_q);
    c_nontrap_overflow: cover property (issue_nt && ovf ##1 result_valid_q);
    c_back_to_back: cover property (do_write ##1 do_write);
    c_unknown_op: cover property (unknown_op_d ##1 unknown_op_q);

endmodule

/* File: test/pipe_model.sv */
/*
 * issuing pipeline model: presents add-format instruction words and
 * loads register file entries through the side write port.
 * assumes the bench calls its tasks; drives only on falling clock edges.
 */
module pipe_model (
    input wire logic clk,
    output logic issue_valid,
    output logic [31:0] instr,
    output logic load_valid,
    output logic [4:0] load_index,
    output logic [63:0] load_data
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        issue_valid = 1'b0;
        instr = 32'h0000_0000;
        load_valid = 1'b0;
        load_index = 5'h0;
        load_data = 64'h0000_0000_0000_0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // field layout, shift zero
    task automatic issue(input logic [5:0] op, input logic [5:0] fn,
                         input logic [4:0] d, input logic [4:0] s, input logic [4:0] t);
        @(negedge clk);
        issue_valid = 1'b1;
        instr = {op, s, t, d, 5'h0, fn};
        @(negedge clk);
        issue_valid = 1'b0;
        // idle word is inverted so a stale value never looks valid
        instr = ~instr;
    endtask

    // two adds back to back, valid held high
    task automatic issue_pair(input logic [5:0] fn_a, input logic [4:0] d_a,
                              input logic [4:0] s_a, input logic [4:0] t_a,
                              input logic [5:0] fn_b, input logic [4:0] d_b,
                              input logic [4:0] s_b, input logic [4:0] t_b);
        @(negedge clk);
        issue_valid = 1'b1;
        instr = {word_add_pkg::OPCODE_SPECIAL, s_a, t_a, d_a, 5'h0, fn_a};
        @(negedge clk);
        instr = {word_add_pkg::OPCODE_SPECIAL, s_b, t_b, d_b, 5'h0, fn_b};
        @(negedge clk);
        issue_valid = 1'b0;
        instr = ~instr;
    endtask

    task automatic load(input logic [4:0] idx, input logic [31:0] w);
        @(negedge clk);
        load_valid = 1'b1;
        load_index = idx;
        load_data = {{32{w[31]}}, w};
        @(negedge clk);
        load_valid = 1'b0;
        load_index = ~idx;
        load_data = ~load_data;
    endtask
endmodule

/* File: test/test_word_add_overflow_trap.sv */
/*
 * self-checking bench for the signed word add datapath.
 * assumes the pipeline model drives issue and load ports at falling edges.
 */
module test_word_add_overflow_trap;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk;
    logic nrst;
    logic [4:0] read_index;
    logic issue_valid, load_valid;
    logic [31:0] instr;
    logic [4:0] load_index;
    logic [63:0] load_data, read_data_q, result_q, flags;
    logic result_valid_q, ovf_exception_q, unknown_op_q;
    int fails = 0;
    int checks = 0;
    int cycles = 0;

    assign flags = {61'h0, result_valid_q, ovf_exception_q, unknown_op_q};

    word_add_overflow_trap i_word_add_overflow_trap (.clk(clk), .nrst(nrst),
        .issue_valid(issue_valid), .instr(instr), .load_valid(load_valid),
        .load_index(load_index), .load_data(load_data), .read_index(read_index),
        .read_data_q(read_data_q), .result_q(result_q), .result_valid_q(result_valid_q),
        .ovf_exception_q(ovf_exception_q), .unknown_op_q(unknown_op_q));

    pipe_model i_pipe_model (.clk(clk), .issue_valid(issue_valid), .instr(instr),
        .load_valid(load_valid), .load_index(load_index), .load_data(load_data));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // read lags one cycle behind the index
    task automatic rd(input logic [4:0] idx, input logic [63:0] exp);
        @(negedge clk);
        read_index = idx;
        @(negedge clk);
        check("gpr", read_data_q, exp);
    endtask

    // hang guard: the sequence needs well under a hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic t_sum();
        i_pipe_model.load(5'h1, 32'h7fff_fff0);
        i_pipe_model.load(5'h2, 32'h0000_000f);
        i_pipe_model.issue(6'h00, word_add_pkg::FUNCT_ADD, 5'h3, 5'h1, 5'h2);
        check("flags", flags, 64'h0000_0000_0000_0004);
        check("result", result_q, 64'h0000_0000_7fff_ffff);
        rd(5'h3, 64'h0000_0000_7fff_ffff);
    endtask

    task automatic t_trap();
        i_pipe_model.load(5'h4, 32'h7fff_ffff);
        i_pipe_model.load(5'h5, 32'h0000_0001);
        i_pipe_model.load(5'h6, 32'h1234_5678);
        i_pipe_model.load(5'h7, 32'h8000_0000);
        i_pipe_model.issue(6'h00, word_add_pkg::FUNCT_ADD, 5'h6, 5'h4, 5'h5);
        check("flags", flags, 64'h0000_0000_0000_0002);
        i_pipe_model.issue(6'h00, word_add_pkg::FUNCT_ADD, 5'h6, 5'h7, 5'h7);
        check("flags", flags, 64'h0000_0000_0000_0002);
        check("result", result_q, 64'h0000_0000_7fff_ffff);
        rd(5'h6, 64'h0000_0000_1234_5678);
    endtask

    // second add reads the destination the first one wrote an edge before
    task automatic t_chain();
        i_pipe_model.issue_pair(word_add_pkg::FUNCT_ADD, 5'h9, 5'h1, 5'h2,
            word_add_pkg::FUNCT_ADD, 5'ha, 5'h9, 5'h7);
        check("flags", flags, 64'h0000_0000_0000_0004);
        check("result", result_q, 64'hffff_ffff_ffff_ffff);
        rd(5'h9, 64'h0000_0000_7fff_ffff);
        rd(5'ha, 64'hffff_ffff_ffff_ffff);
    endtask

    task automatic t_nontrap();
        i_pipe_model.issue(6'h00, word_add_pkg::FUNCT_SUM_NONTRAP, 5'h8, 5'h4, 5'h5);
        check("flags", flags, 64'h0000_0000_0000_0004);
        check("result", result_q, 64'hffff_ffff_8000_0000);
        rd(5'h8, 64'hffff_ffff_8000_0000);
    endtask

    // mid-run reset clears the outputs but not the register file
    task automatic t_reset();
        @(negedge clk);
        nrst = 1'b0;
        read_index = 5'h8;
        @(negedge clk);
        check("flags", flags, 64'h0000_0000_0000_0000); // reset value
        check("result", result_q, word_add_pkg::RESULT_RST); // reset value
        check("gpr", read_data_q, word_add_pkg::RESULT_RST); // reset value
        nrst = 1'b1;
        rd(5'h8, 64'hffff_ffff_8000_0000);
    endtask

    task automatic t_unknown();
        logic [11:0] codes [2] = '{12'h022, 12'h220};
        foreach (codes[i])
        begin
            i_pipe_model.issue(codes[i][11:6], codes[i][5:0], 5'h1, 5'h4, 5'h5);
            check("flags", flags, 64'h0000_0000_0000_0001);
            rd(5'h1, 64'h0000_0000_7fff_fff0);
        end
    endtask

    initial
    begin
        nrst = 1'b0;
        read_index = 5'h0;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        t_sum();
        t_trap();
        t_chain();
        t_nontrap();
        t_reset();
        t_unknown();
        summarize();
    end
endmodule
